// file: core/pim_pkg.sv
package pim_pkg;
   // ahb register byte offsets
   localparam logic [7:0] PIM_OFF_CTRL   = 8'h00;  // bit0 enables the data-line driver
   localparam logic [7:0] PIM_OFF_MASK   = 8'h04;  // interrupt mask, status layout
   localparam logic [7:0] PIM_OFF_STATUS = 8'h08;  // sticky events, cleared by read
   localparam logic [7:0] PIM_OFF_STATE  = 8'h0C;  // live steering and coin state
   // reset values
   localparam logic [31:0] PIM_CTRL_RST  = 32'h0000_0001;
   localparam logic [3:0]  PIM_MASK_RST  = 4'h0;
   // status bits: steer p1, steer p2, coin 1, coin 2
   localparam int PIM_EV_W = 4;
   // selector positions on the two upper address lines
   localparam logic [1:0] PIM_SEL_SWITCH = 2'b00;
   localparam logic [1:0] PIM_SEL_STEER1 = 2'b01;
   localparam logic [1:0] PIM_SEL_STEER2 = 2'b10;
   localparam logic [1:0] PIM_SEL_COIN   = 2'b11;
   // switch group codes on address bits {5,4,3}
   localparam logic [2:0] PIM_GRP_GEAR   = 3'b011;
   localparam logic [2:0] PIM_GRP_PANEL  = 3'b101;
   // option group on address bits {4,3}
   localparam logic [1:0] PIM_GRP_OPTION = 2'b10;
   // pin-bus widths
   localparam int PIM_ADR_W = 8;
   localparam int PIM_SW_W  = 7;
   localparam int PIM_OPT_W = 4;
   // bus data-phase state
   typedef enum logic [1:0]
   {
      PIM_PH_IDLE = 2'b00,
      PIM_PH_WR   = 2'b01,
      PIM_PH_RD   = 2'b10
   } pim_phase_t;
endpackage : pim_pkg

// file: core/pim_player_input_mux.sv
`timescale 1ns/1ps
`default_nettype none
module pim_player_input_mux
(
   input  wire logic                           hclk,
   input  wire logic                           hresetn,
   // ahb-lite slave
   input  wire logic                           hsel,
   input  wire logic [31:0]                    haddr,
   input  wire logic [1:0]                     htrans,
   input  wire logic                           hwrite,
   input  wire logic [2:0]                     hsize,
   input  wire logic [31:0]                    hwdata,
   input  wire logic                           hready,
   output logic      [31:0]                    hrdata,
   output logic                                hreadyout,
   output logic                                hresp,
   output logic                                irq,
   // host processor pins
   input  wire logic [pim_pkg::PIM_ADR_W-1:0]  cpu_adr,
   input  wire logic                           switch_rd_n,
   input  wire logic                           steer_clr1_n,
   input  wire logic                           steer_clr2_n,
   output logic      [1:0]                     cpu_d_out,
   output logic                                cpu_d_oe,
   // operator pins
   input  wire logic                           steer_a1,
   input  wire logic                           steer_b1,
   input  wire logic                           steer_a2,
   input  wire logic                           steer_b2,
   input  wire logic [1:0]                     coin_n,
   input  wire logic [pim_pkg::PIM_SW_W-1:0]   gear_sw_n,
   input  wire logic [pim_pkg::PIM_SW_W-1:0]   panel_sw_n,
   input  wire logic [pim_pkg::PIM_OPT_W-1:0]  opt_upper_n,
   input  wire logic [pim_pkg::PIM_OPT_W-1:0]  opt_lower_n
);
   import pim_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   localparam int PW = PIM_ADR_W + 3 + 4 + 2 + 2 * PIM_SW_W + 2 * PIM_OPT_W;
   logic [PW-1:0] pin_raw;                    // all asynchronous pins
   logic [PW-1:0] pin_q1_r;                   // first stage, read by second only
   logic [PW-1:0] pin_q2_r;                   // safe copy for logic

   assign pin_raw = {cpu_adr, switch_rd_n, steer_clr1_n, steer_clr2_n,
                     steer_a1, steer_b1, steer_a2, steer_b2, coin_n,
                     gear_sw_n, panel_sw_n, opt_upper_n, opt_lower_n};

   // two flops per pin; reset to the idle (high) level of strobes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_q1_r <= '1;
         pin_q2_r <= '1;
      end
      else
      begin
         pin_q1_r <= pin_raw;
         pin_q2_r <= pin_q1_r;
      end
   end

   logic [PIM_ADR_W-1:0] adr_s;                // synced address
   logic                 rd_n_s;               // synced read strobe
   logic [1:0]           clr_n_s;              // synced clear strobes
   logic [1:0]           a_s;                  // synced phase a per player
   logic [1:0]           b_s;                  // synced phase b per player
   logic [1:0]           coin_n_s;             // synced coin inputs
   logic [PIM_SW_W-1:0]  gear_s;               // synced gear switches
   logic [PIM_SW_W-1:0]  panel_s;              // synced panel switches
   logic [PIM_OPT_W-1:0] optu_s;               // synced upper options
   logic [PIM_OPT_W-1:0] optl_s;               // synced lower options

   assign {adr_s, rd_n_s, clr_n_s[0], clr_n_s[1], a_s[0], b_s[0], a_s[1], b_s[1],
           coin_n_s, gear_s, panel_s, optu_s, optl_s} = pin_q2_r;

   ////////////////////////////////////////////////////////////////////////////
   // steering flip-flops and coin edges
   logic [1:0] move_r, move_nxt;               // movement seen, per player
   logic [1:0] dir_r, dir_nxt;                 // phase order, high = a leads
   logic [1:0] b_prev_r;                       // previous phase b
   logic [1:0] coin_prev_r;                    // previous coin level
   logic [1:0] b_fall;                         // rising edge of inverted b
   logic [1:0] coin_fall;                      // coin pulse start

   assign b_fall    = b_prev_r & ~b_s;
   assign coin_fall = coin_prev_r & ~coin_n_s;

   // inverted b clocks inverted a into the direction flop; set beats clear
   always_comb
   begin
      move_nxt = move_r;
      dir_nxt  = dir_r;
      for (int p = 0; p < 2; p++)
      begin
         if (!clr_n_s[p])
            move_nxt[p] = 1'b0;                // host acknowledge
         if (b_fall[p])
         begin
            move_nxt[p] = 1'b1;                // movement latched
            dir_nxt[p]  = ~a_s[p];             // a already low means a leads
         end
      end
   end

   // register the steering state
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         move_r      <= 2'b00;
         dir_r       <= 2'b00;
         b_prev_r    <= 2'b11;
         coin_prev_r <= 2'b11;
      end
      else
      begin
         move_r      <= move_nxt;
         dir_r       <= dir_nxt;
         b_prev_r    <= b_s;
         coin_prev_r <= coin_n_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // selector and data-line driver
   // pick one of seven switches; position 7 reads as open
   function automatic logic pick_sw(input logic [PIM_SW_W-1:0] v, input logic [2:0] pos);
      pick_sw = (pos == 3'd7) ? 1'b1 : v[pos];
   endfunction

   logic       ctrl_en;                        // software driver enable
   logic [1:0] in0;                            // switch pair {upper, lower}
   logic [1:0] d_out_r, d_out_nxt;             // {d7, d6}
   logic       d_oe_r, d_oe_nxt;               // driver enable

   // position-0 inputs from the switch decoders; unmatched reads open
   always_comb
   begin
      in0 = 2'b11;
      if (adr_s[5:3] == PIM_GRP_GEAR)
         in0 = {pick_sw(gear_s, adr_s[2:0]), 1'b1};   // gear group
      else if (adr_s[5:3] == PIM_GRP_PANEL)
         in0 = {pick_sw(panel_s, adr_s[2:0]), 1'b1};  // pedals, test, start
      else if (adr_s[4:3] == PIM_GRP_OPTION)
         in0 = {optu_s[adr_s[1:0]], optl_s[adr_s[1:0]]}; // options
   end

   // four-way, two-pole selector on address bits 7:6
   always_comb
   begin
      case (adr_s[7:6])
         PIM_SEL_SWITCH: d_out_nxt = in0;
         PIM_SEL_STEER1: d_out_nxt = {~move_r[0], dir_r[0]};
         PIM_SEL_STEER2: d_out_nxt = {~move_r[1], dir_r[1]};
         PIM_SEL_COIN:   d_out_nxt = coin_n_s; // host counts lows
         default:        d_out_nxt = 2'b11;
      endcase
      d_oe_nxt = ~rd_n_s & ctrl_en;
   end

   // outputs straight from flops; one cycle behind the synced strobe
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         d_out_r <= 2'b11;
         d_oe_r  <= 1'b0;
      end
      else
      begin
         d_out_r <= d_out_nxt;
         d_oe_r  <= d_oe_nxt;
      end
   end

   assign cpu_d_out = d_out_r;
   assign cpu_d_oe  = d_oe_r;

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite register slave, zero wait states
   logic                ctrl_r, ctrl_nxt;      // driver enable bit
   logic [PIM_EV_W-1:0] mask_r, mask_nxt;      // interrupt mask
   logic [PIM_EV_W-1:0] stat_r, stat_nxt;      // sticky events
   logic [PIM_EV_W-1:0] events;                // one-cycle event pulses
   logic [31:0]         rdata_r, rdata_nxt;    // read data for data phase
   logic [7:0]          waddr_r, waddr_nxt;    // write address held
   pim_phase_t          ph_r, ph_nxt;          // data-phase kind
   logic                irq_r, irq_nxt;        // interrupt level
   logic                take;                  // address phase accepted

   assign ctrl_en = ctrl_r;
   assign events  = {coin_fall, b_fall};
   assign take    = hsel & htrans[1] & hready;

   // decode, read-to-clear and write data phase
   always_comb
   begin
      ctrl_nxt  = ctrl_r;
      mask_nxt  = mask_r;
      waddr_nxt = waddr_r;
      ph_nxt    = PIM_PH_IDLE;
      rdata_nxt = rdata_r;
      stat_nxt  = stat_r;
      if (ph_r == PIM_PH_WR)                   // unmapped writes are dropped
      begin
         if (waddr_r == PIM_OFF_CTRL)
            ctrl_nxt = hwdata[0];
         else if (waddr_r == PIM_OFF_MASK)
            mask_nxt = hwdata[PIM_EV_W-1:0];
      end
      if (take)
      begin
         waddr_nxt = haddr[7:0];
         ph_nxt    = hwrite ? PIM_PH_WR : PIM_PH_RD;
         if (!hwrite)
         begin
            case (haddr[7:0])                  // unmapped reads return zero
               PIM_OFF_CTRL:   rdata_nxt = {31'h0000_0000, ctrl_r};
               PIM_OFF_MASK:   rdata_nxt = {28'h000_0000, mask_r};
               PIM_OFF_STATUS:
               begin
                  rdata_nxt = {28'h000_0000, stat_r};
                  stat_nxt  = '0;
               end
               PIM_OFF_STATE:  rdata_nxt = {26'h000_0000, coin_n_s, dir_r, move_r};
               default:        rdata_nxt = 32'h0000_0000;
            endcase
         end
      end
      stat_nxt = stat_nxt | events;            // a new event outlives the clearing read
      irq_nxt  = |(stat_nxt & mask_nxt);
   end

   // register bus state
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_r  <= PIM_CTRL_RST[0];
         mask_r  <= PIM_MASK_RST;
         stat_r  <= '0;
         rdata_r <= 32'h0000_0000;
         waddr_r <= 8'h00;
         ph_r    <= PIM_PH_IDLE;
         irq_r   <= 1'b0;
      end
      else
      begin
         ctrl_r  <= ctrl_nxt;
         mask_r  <= mask_nxt;
         stat_r  <= stat_nxt;
         rdata_r <= rdata_nxt;
         waddr_r <= waddr_nxt;
         ph_r    <= ph_nxt;
         irq_r   <= irq_nxt;
      end
   end

   // never stalls, always okay: the one-flop answer is always ready
   logic rdy_r;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rdy_r <= 1'b1;                        // ready through reset, so no glue on the port
      else
         rdy_r <= 1'b1;
   end

   assign hrdata    = rdata_r;
   assign hreadyout = rdy_r;
   assign hresp     = 1'b0;
   assign irq       = irq_r;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_steer_rd1;
      !rd_n_s && ctrl_r && adr_s[7:6] == PIM_SEL_STEER1;
   endsequence

   sequence s_moved1;
      b_fall[0] && clr_n_s[0];
   endsequence

   sel_route_a: assert property (s_steer_rd1 |=>
      d_out_r == {~$past(move_r[0]), $past(dir_r[0])})
      else $error("selector did not route steering pair");

   oe_strobe_a: assert property ((!rd_n_s && ctrl_r)[*2] |=>
      d_oe_r[*1])
      else $error("driver not enabled during read strobe");

   oe_release_a: assert property (rd_n_s |=> !d_oe_r)
      else $error("data lines driven without strobe");

   steer_capture_a: assert property (s_moved1 |=>
      move_r[0] && dir_r[0] == ~$past(a_s[0]))
      else $error("steering edge not captured");

   move_read_a: assert property ((s_steer_rd1 and move_r[0]) |=>
      !d_out_r[1] && d_out_r[0] == $past(dir_r[0]))
      else $error("movement did not read low on d7");

   steer_clear_a: assert property ((!clr_n_s[1] && !b_fall[1]) |=> !move_r[1])
      else $error("clear strobe did not reset flop");

   gear_switch_a: assert property ((adr_s[7:6] == PIM_SEL_SWITCH
      && adr_s[5:3] == PIM_GRP_GEAR && adr_s[2:0] != 3'd7) |=>
      d_out_r == {$past(gear_s[adr_s[2:0]]), 1'b1})
      else $error("gear switch level wrong");

   panel_switch_a: assert property ((adr_s[7:6] == PIM_SEL_SWITCH
      && adr_s[5:3] == PIM_GRP_PANEL && adr_s[2:0] == 3'd0) |=>
      d_out_r[1] == $past(panel_s[0]))
      else $error("panel switch level wrong");

   option_read_a: assert property ((adr_s[7:6] == PIM_SEL_SWITCH
      && adr_s[4:3] == PIM_GRP_OPTION) |=>
      d_out_r == {$past(optu_s[adr_s[1:0]]), $past(optl_s[adr_s[1:0]])})
      else $error("option pair wrong");

endmodule : pim_player_input_mux // pim_player_input_mux
`default_nettype wire

// file: verification/pim_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host processor side of the input pins: it addresses the selector, pulls the
// read strobe and issues the steering clear strobes
module pim_host_model
(
   input  wire logic       hclk,
   input  wire logic [1:0] d_wire,  // resolved d7/d6 lines
   output logic      [7:0] adr,     // host address pins
   output logic            rd_n,    // input-read strobe
   output logic            clr1_n,  // steering clear, player one
   output logic            clr2_n   // steering clear, player two
);
   // all strobes idle from time zero
   initial
   begin
      adr    = 8'h00;
      rd_n   = 1'b1;
      clr1_n = 1'b1;
      clr2_n = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one input read: address and strobe held for five edges, which covers the
   // two sync stages plus the output flop, then released before the next read
   task automatic rd(input logic [7:0] a, output logic [1:0] d);
      @(posedge hclk);
      adr  <= a;
      rd_n <= 1'b0;
      repeat (5) @(posedge hclk);
      d = d_wire;  // the caller compares this with its expected levels
      rd_n <= 1'b1;
      repeat (4) @(posedge hclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // steering clear after a movement was handled, held past the sync stages
   task automatic clr(input int p);
      @(posedge hclk);
      if (p == 0) clr1_n <= 1'b0;
      else        clr2_n <= 1'b0;
      repeat (4) @(posedge hclk);
      clr1_n <= 1'b1;
      clr2_n <= 1'b1;
      repeat (4) @(posedge hclk);
   endtask
endmodule // pim_host_model
`default_nettype wire

// file: verification/tb_player_input_multiplexer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_player_input_multiplexer;
   import pim_pkg::*;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r;
   logic [1:0]  htrans = 2'h0, cpu_d_out, d_wire, dv, coin_n = 2'h3;
   logic [2:0]  hsize = 3'h2;
   logic        hready, hreadyout, hresp, irq, cpu_d_oe, rd_n, clr1_n, clr2_n;
   logic [7:0]  adr, a;
   logic [1:0]  sa = 2'h3, sb = 2'h3;             // steering phases, idle high
   logic [6:0]  gear_sw_n = 7'h7F, panel_sw_n = 7'h7F;
   logic [3:0]  opt_upper_n = 4'hF, opt_lower_n = 4'hF;
   int          errors = 0, cmp_count = 0;

   always #50 hclk = ~hclk;
   assign hready = hreadyout;                     // single slave on the bus
   // released lines float up to the pull-ups
   assign d_wire = cpu_d_oe ? cpu_d_out : 2'h3;

   pim_player_input_mux uut
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .irq(irq), .cpu_adr(adr), .switch_rd_n(rd_n), .steer_clr1_n(clr1_n),
      .steer_clr2_n(clr2_n), .cpu_d_out(cpu_d_out), .cpu_d_oe(cpu_d_oe),
      .steer_a1(sa[0]), .steer_b1(sb[0]), .steer_a2(sa[1]), .steer_b2(sb[1]),
      .coin_n(coin_n), .gear_sw_n(gear_sw_n), .panel_sw_n(panel_sw_n),
      .opt_upper_n(opt_upper_n), .opt_lower_n(opt_lower_n)
   );

   pim_host_model host
   (
      .hclk(hclk), .d_wire(d_wire), .adr(adr), .rd_n(rd_n),
      .clr1_n(clr1_n), .clr2_n(clr2_n)
   );

   ////////////////////////////////////////////////////////////////////////////
   // one comparison, counted
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   // single ahb-lite transfer; waits on hready, never on a fixed count
   task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, ad};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // reference selector for switch positions
   function automatic logic [1:0] exp_sw(input logic [7:0] x);
      if (x[4:3] == PIM_GRP_OPTION) return {opt_upper_n[x[1:0]], opt_lower_n[x[1:0]]};
      if (x[2:0] == 3'h7) return 2'h3;
      if (x[5:3] == PIM_GRP_GEAR) return {gear_sw_n[x[2:0]], 1'h1};
      if (x[5:3] == PIM_GRP_PANEL) return {panel_sw_n[x[2:0]], 1'h1};
      return 2'h3;
   endfunction

   // quadrature movement: phase a set first, then phase b falls
   task automatic steer(input int p, input logic d);
      @(posedge hclk);
      sb[p] <= 1'b1;
      repeat (4) @(posedge hclk);
      sa[p] <= ~d;  // a leads b for a right turn
      repeat (4) @(posedge hclk);
      sb[p] <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // cuts a hang short; the whole run needs far less
   initial
   begin
      #2_000_000;
      errors++;
      test_done();
   end

   initial
   begin
      void'($urandom(61));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values and an unmapped place
      chk(32'(cpu_d_oe), 32'h0000_0000);
      ahb(1'b0, PIM_OFF_CTRL, 32'h0000_0000, r);
      chk(r, PIM_CTRL_RST);
      chk(32'(hresp), 32'h0000_0000);                    // okay response
      ahb(1'b0, PIM_OFF_MASK, 32'h0000_0000, r);
      chk(r, 32'(PIM_MASK_RST));
      ahb(1'b0, 8'h10, 32'h0000_0000, r);
      chk(r, 32'h0000_0000);
      ahb(1'b0, PIM_OFF_STATUS, 32'h0000_0000, r);
      $display("test registers done");
      // gear, panel and option groups with random switch states
      for (int i = 0; i < 36; i++)
      begin
         @(posedge hclk);
         gear_sw_n   <= 7'($urandom);
         panel_sw_n  <= 7'($urandom);
         opt_upper_n <= 4'($urandom);
         opt_lower_n <= 4'($urandom);
         a = 8'($urandom);
         if (i % 3 == 0) a = {2'h0, PIM_GRP_GEAR, a[2:0]};
         else if (i % 3 == 1) a = {2'h0, PIM_GRP_PANEL, a[2:0]};
         else a = {2'h0, a[5], PIM_GRP_OPTION, a[2:0]};
         host.rd(a, dv);
         chk(32'(dv), 32'(exp_sw(a)));
         chk(32'(cpu_d_oe), 32'h0000_0000);
      end
      $display("test switches done");
      // steering both players, both directions, then clear
      for (int p = 0; p < 2; p++)
         for (int d = 0; d < 2; d++)
         begin
            a = (p == 0) ? {PIM_SEL_STEER1, 6'h00} : {PIM_SEL_STEER2, 6'h00};
            steer(p, d[0]);
            host.rd(a, dv);
            chk(32'(dv), {30'h0, 1'h0, d[0]});
            ahb(1'b0, PIM_OFF_STATUS, 32'h0000_0000, r);
            chk(r, 32'h0000_0001 << p);
            chk(32'(irq), 32'h0000_0000);
            host.clr(p);
            host.rd(a, dv);
            chk(32'(dv[1]), 32'h0000_0001);
         end
      // live state: both flops cleared, last order a leads, coins idle
      ahb(1'b0, PIM_OFF_STATE, 32'h0000_0000, r);
      chk(r, 32'h0000_003C);
      $display("test steering done");
      // coin events: unmasked raises the interrupt, masked does not
      ahb(1'b1, PIM_OFF_MASK, 32'h0000_0004, r);
      coin_n <= 2'h2;
      repeat (5) @(posedge hclk);
      chk(32'(irq), 32'h0000_0001);
      host.rd({PIM_SEL_COIN, 6'h00}, dv);
      // d7 carries coin_n[1], d6 carries coin_n[0]
      chk(32'(dv), 32'(coin_n));
      ahb(1'b0, PIM_OFF_STATUS, 32'h0000_0000, r);
      chk(r, 32'h0000_0004);
      repeat (3) @(posedge hclk);
      chk(32'(irq), 32'h0000_0000);
      coin_n <= 2'h1;
      repeat (5) @(posedge hclk);
      chk(32'(irq), 32'h0000_0000);
      ahb(1'b0, PIM_OFF_STATUS, 32'h0000_0000, r);
      chk(r, 32'h0000_0008);
      coin_n <= 2'h3;
      $display("test coins done");
      // driver disabled: the lines stay with the pull-ups
      gear_sw_n <= 7'h00;
      ahb(1'b1, PIM_OFF_CTRL, 32'h0000_0000, r);
      host.rd({2'h0, PIM_GRP_GEAR, 3'h0}, dv);
      chk(32'(dv), 32'h0000_0003);
      ahb(1'b1, PIM_OFF_CTRL, 32'h0000_0001, r);
      host.rd({2'h0, PIM_GRP_GEAR, 3'h0}, dv);
      chk(32'(dv), 32'h0000_0001);
      $display("test driver enable done");
      test_done();
   end
endmodule // tb_player_input_multiplexer
`default_nettype wire
